//--- hw/bmd_decoder.v
// Block move instruction decoder and byte mover
//
// Functional notes
// - Top two bits of first word select one of four instruction types.
// - Type 01 exposes bits 29-27 as the I/O or read/write opcode.
// - First word fills command and counter; second fills pointer save.
// - Only memory move fetches a third word, into the return stack.
// - Chained move holds an odd leftover byte to pair with next move.
// - Direct mode loads start address and increments it per byte.
// - Indirect mode fetches real address into pointer save, then direct.
// - Table mode adds signed 24-bit offset to structure base.
// - Table entry gives count word then 32-bit buffer address.
// - Table words are little endian, low byte at low address.
// - Indirect plus table-indirect together is an illegal instruction.
// - Target role: bit 27 clear is plain move, set is chained move.
// - Target waits for bus ready, then drives phase; initiator senses.
// - Target command phase sizes count from first byte's group code.
// - Unknown group code keeps the count already in the counter.
// - Zero command length stops after first byte with an interrupt.
// - Other target phases move exactly the instruction's byte count.
// - Attention during target move may finish, then interrupts.
// - Data passes a buffer so receiver stalls lose nothing.
// - Initiator: bit 27 set is plain; phase mismatch interrupts, halts.
// - Bits 26-24 compared with phase latched at request.
// - Bits 23-0 load counter; decrement per byte, fetch next at zero.
`timescale 1ns/10ps
`include "bmd_consts.vh"
module bmd_decoder #(
    parameter BUF_W = 49
) (
    // Clock and reset
    input wire CLK,
    input wire RST,
    // Control
    input wire GO,
    input wire [31:0] START_PTR,
    input wire TARGET_MODE,
    input wire BUS_READY,
    input wire ATN_FINISH,
    input wire ATN,
    input wire [31:0] STRUCTURE_BASE_REG,
    // Instruction and table fetch
    output reg FETCH_REQ,
    output reg [31:0] FETCH_ADDR,
    input wire FETCH_ACK,
    input wire [31:0] FETCH_DATA,
    // Bus phase
    input wire PHASE_VALID,
    input wire [2:0] LATCHED_PHASE_STATUS,
    output reg [2:0] PHASE_OUT,
    output reg PHASE_OE,
    // Byte stream in
    input wire IN_VALID,
    input wire [7:0] IN_DATA,
    output reg IN_READY,
    // Wide word stream out
    output wire OUT_VALID,
    output wire [15:0] OUT_DATA,
    output wire [31:0] OUT_ADDR,
    output wire OUT_LAST,
    input wire OUT_READY,
    // Decoded state
    output reg [1:0] INSTR_TYPE,
    output reg [2:0] IO_OPCODE,
    output reg [7:0] COMMAND_CODE_REG,
    output reg [23:0] TRANSFER_BYTE_COUNTER,
    output reg [31:0] POINTER_SAVE_REG,
    output reg [31:0] RETURN_STACK_REG,
    output reg [31:0] NEXT_DATA_ADDRESS_REG,
    output reg [31:0] INSTR_PTR,
    output reg CHAINED_BLOCK_MOVE,
    // Status
    output reg BUSY,
    output reg DONE,
    output reg ILLEGAL_INT,
    output reg MISMATCH_INT,
    output reg CMD_ZERO_INT,
    output reg ATN_INT
);
    localparam S_IDLE = 4'h0;
    localparam S_F1 = 4'h1;
    localparam S_F2 = 4'h2;
    localparam S_F3 = 4'h3;
    localparam S_DEC = 4'h4;
    localparam S_IND = 4'h5;
    localparam S_TB1 = 4'h6;
    localparam S_TB2 = 4'h7;
    localparam S_PH = 4'h8;
    localparam S_CMD = 4'h9;
    localparam S_XFER = 4'hA;
    localparam S_END = 4'hB;
    localparam S_HALT = 4'hC;

    reg [3:0] state_q;
    reg [31:0] word1_q;
    reg [7:0] lo_q;
    reg have_lo_q;
    reg [31:0] lo_addr_q;
    reg pend_q;
    reg [15:0] pend_data_q;
    reg [31:0] pend_addr_q;
    reg pend_last_q;
    reg atn_seen_q;
    wire fetched;
    wire accept;
    wire pend_take;
    wire [23:0] grp_len;
    wire grp_ok;
    wire [31:0] tbl_addr;
    wire is_cmd;

    assign fetched = FETCH_REQ & FETCH_ACK;
    assign accept = IN_VALID & IN_READY;
    // Table entry address from sign-extended offset
    assign tbl_addr = STRUCTURE_BASE_REG
        + {{8{POINTER_SAVE_REG[`BMD_OFS_SIGN]}}, POINTER_SAVE_REG[23:0]};
    assign is_cmd = TARGET_MODE &&
        (word1_q[`BMD_PH_HI:`BMD_PH_LO] == `BMD_PHASE_CMD);

    // Command group code lookup
    bmd_grp_len u_grp (
        .cmd_byte(IN_DATA),
        .cmd_len(grp_len),
        .len_ok(grp_ok)
    );

    // Word buffer between mover and receiver
    bmd_buf2 #(.W(BUF_W)) u_buf (
        .clk(CLK),
        .rst(RST),
        .in_valid(pend_q),
        .in_data({pend_last_q, pend_addr_q, pend_data_q}),
        .in_ready(pend_take),
        .out_valid(OUT_VALID),
        .out_data({OUT_LAST, OUT_ADDR, OUT_DATA}),
        .out_ready(OUT_READY)
    );

    // Input ready pulses once per byte, only with room; in a move also only with count left, the command byte needs none
    always @(posedge CLK) begin
        if (RST) begin
            IN_READY <= 1'b0;
        end else if (accept) begin
            IN_READY <= 1'b0;
        end else begin
            IN_READY <= ((state_q == S_XFER &&
                TRANSFER_BYTE_COUNTER != `BMD_RST_CNT) ||
                state_q == S_CMD) && !pend_q;
        end
    end

    // Pending word register feeding the buffer
    always @(posedge CLK) begin
        if (RST) begin
            pend_q <= 1'b0;
            pend_data_q <= 16'h0000;
            pend_addr_q <= `BMD_RST_WORD;
            pend_last_q <= 1'b0;
        end else if (accept && have_lo_q) begin
            pend_q <= 1'b1; // Pair completes a wide word
            pend_data_q <= {IN_DATA, lo_q};
            pend_addr_q <= lo_addr_q;
            pend_last_q <= 1'b0;
        end else if (state_q == S_END && have_lo_q &&
                     !CHAINED_BLOCK_MOVE && !pend_q) begin
            pend_q <= 1'b1; // Odd byte of a plain move goes out alone
            pend_data_q <= {8'h00, lo_q};
            pend_addr_q <= lo_addr_q;
            pend_last_q <= 1'b1;
        end else if (pend_take) begin
            pend_q <= 1'b0;
        end
    end

    // Sequencer: fetch, decode, move, advance
    always @(posedge CLK) begin
        if (RST) begin
            state_q <= S_IDLE;
            word1_q <= `BMD_RST_WORD;
            FETCH_REQ <= 1'b0;
            FETCH_ADDR <= `BMD_RST_WORD;
            PHASE_OUT <= 3'h0;
            PHASE_OE <= 1'b0;
            INSTR_TYPE <= 2'h0;
            IO_OPCODE <= 3'h0;
            COMMAND_CODE_REG <= 8'h00;
            TRANSFER_BYTE_COUNTER <= `BMD_RST_CNT;
            POINTER_SAVE_REG <= `BMD_RST_WORD;
            RETURN_STACK_REG <= `BMD_RST_WORD;
            NEXT_DATA_ADDRESS_REG <= `BMD_RST_WORD;
            INSTR_PTR <= `BMD_RST_WORD;
            CHAINED_BLOCK_MOVE <= 1'b0;
            BUSY <= 1'b0;
            DONE <= 1'b0;
            ILLEGAL_INT <= 1'b0;
            MISMATCH_INT <= 1'b0;
            CMD_ZERO_INT <= 1'b0;
            ATN_INT <= 1'b0;
            lo_q <= 8'h00;
            have_lo_q <= 1'b0;
            lo_addr_q <= `BMD_RST_WORD;
            atn_seen_q <= 1'b0;
        end else begin
            DONE <= 1'b0;
            if (fetched) begin
                FETCH_REQ <= 1'b0;
            end
            // Byte accepted: count down, address up
            if (accept) begin
                NEXT_DATA_ADDRESS_REG <= NEXT_DATA_ADDRESS_REG
                    + 32'h00000001;
                if (!have_lo_q) begin
                    lo_q <= IN_DATA;
                    lo_addr_q <= NEXT_DATA_ADDRESS_REG;
                end
                have_lo_q <= !have_lo_q;
            end
            case (state_q)
                S_IDLE, S_HALT: begin
                    if (GO) begin
                        INSTR_PTR <= START_PTR;
                        FETCH_ADDR <= START_PTR;
                        FETCH_REQ <= 1'b1;
                        BUSY <= 1'b1;
                        ILLEGAL_INT <= 1'b0;
                        MISMATCH_INT <= 1'b0;
                        CMD_ZERO_INT <= 1'b0;
                        ATN_INT <= 1'b0;
                        state_q <= S_F1;
                    end
                end
                S_F1: begin
                    if (fetched) begin
                        // First word to command and counter
                        word1_q <= FETCH_DATA;
                        COMMAND_CODE_REG <=
                            FETCH_DATA[`BMD_CMD_HI:`BMD_CMD_LO];
                        TRANSFER_BYTE_COUNTER <=
                            FETCH_DATA[`BMD_CNT_HI:`BMD_CNT_LO];
                        INSTR_TYPE <=
                            FETCH_DATA[`BMD_TYPE_HI:`BMD_TYPE_LO];
                        IO_OPCODE <=
                            FETCH_DATA[`BMD_IO_OP_HI:`BMD_IO_OP_LO];
                        FETCH_ADDR <= FETCH_ADDR + `BMD_WORD_STEP;
                        FETCH_REQ <= 1'b1;
                        state_q <= S_F2;
                    end
                end
                S_F2: begin
                    if (fetched) begin
                        POINTER_SAVE_REG <= FETCH_DATA;
                        NEXT_DATA_ADDRESS_REG <= FETCH_DATA;
                        if (INSTR_TYPE == `BMD_TYPE_MEMMOVE) begin
                            FETCH_ADDR <= FETCH_ADDR + `BMD_WORD_STEP;
                            FETCH_REQ <= 1'b1;
                            state_q <= S_F3;
                        end else begin
                            state_q <= S_DEC;
                        end
                    end
                end
                S_F3: begin
                    if (fetched) begin
                        RETURN_STACK_REG <= FETCH_DATA;
                        INSTR_PTR <= INSTR_PTR + `BMD_STEP_THREE;
                        DONE <= 1'b1;
                        BUSY <= 1'b0;
                        state_q <= S_IDLE;
                    end
                end
                S_DEC: begin
                    // Opcode sense depends on role
                    CHAINED_BLOCK_MOVE <= TARGET_MODE ?
                        word1_q[`BMD_OPC_BIT] : !word1_q[`BMD_OPC_BIT];
                    atn_seen_q <= 1'b0;
                    if (INSTR_TYPE != `BMD_TYPE_BLOCK) begin
                        // Other types are handed on after two words
                        INSTR_PTR <= INSTR_PTR + `BMD_STEP_TWO;
                        DONE <= 1'b1;
                        BUSY <= 1'b0;
                        state_q <= S_IDLE;
                    end else if (word1_q[`BMD_IND_BIT] &&
                                 word1_q[`BMD_TBL_BIT]) begin
                        ILLEGAL_INT <= 1'b1; // Before any indirect or table fetch
                        BUSY <= 1'b0;
                        state_q <= S_HALT;
                    end else if (word1_q[`BMD_IND_BIT]) begin
                        FETCH_ADDR <= POINTER_SAVE_REG;
                        FETCH_REQ <= 1'b1;
                        state_q <= S_IND;
                    end else if (word1_q[`BMD_TBL_BIT]) begin
                        FETCH_ADDR <= tbl_addr;
                        FETCH_REQ <= 1'b1;
                        state_q <= S_TB1;
                    end else begin
                        state_q <= S_PH;
                    end
                end
                S_IND: begin
                    if (fetched) begin
                        POINTER_SAVE_REG <= FETCH_DATA;
                        NEXT_DATA_ADDRESS_REG <= FETCH_DATA;
                        state_q <= S_PH;
                    end
                end
                S_TB1: begin
                    if (fetched) begin
                        // Low byte at low address, top byte zero
                        TRANSFER_BYTE_COUNTER <= FETCH_DATA[23:0];
                        FETCH_ADDR <= FETCH_ADDR + `BMD_WORD_STEP;
                        FETCH_REQ <= 1'b1;
                        state_q <= S_TB2;
                    end
                end
                S_TB2: begin
                    if (fetched) begin
                        NEXT_DATA_ADDRESS_REG <= FETCH_DATA;
                        state_q <= S_PH;
                    end
                end
                S_PH: begin
                    if (TARGET_MODE) begin
                        if (BUS_READY) begin
                            // Drive phase lines as coded
                            PHASE_OUT <= word1_q[`BMD_PH_HI:`BMD_PH_LO];
                            PHASE_OE <= 1'b1;
                            state_q <= is_cmd ? S_CMD : S_XFER;
                        end
                    end else if (PHASE_VALID) begin
                        // Initiator senses and compares phase
                        if (LATCHED_PHASE_STATUS !=
                            word1_q[`BMD_PH_HI:`BMD_PH_LO]) begin
                            MISMATCH_INT <= 1'b1;
                            BUSY <= 1'b0;
                            state_q <= S_HALT;
                        end else begin
                            state_q <= S_XFER;
                        end
                    end
                end
                S_CMD: begin
                    if (accept) begin
                        if (!grp_ok) begin
                            // Keep the held count
                            TRANSFER_BYTE_COUNTER <= TRANSFER_BYTE_COUNTER
                                - 24'h000001;
                            state_q <= S_XFER;
                        end else if (grp_len == `BMD_RST_CNT) begin
                            TRANSFER_BYTE_COUNTER <= `BMD_RST_CNT;
                            CMD_ZERO_INT <= 1'b1;
                            state_q <= S_END;
                        end else begin
                            TRANSFER_BYTE_COUNTER <= grp_len
                                - 24'h000001;
                            state_q <= S_XFER;
                        end
                    end
                end
                S_XFER: begin
                    if (accept) begin
                        TRANSFER_BYTE_COUNTER <= TRANSFER_BYTE_COUNTER
                            - 24'h000001;
                    end
                    if (TARGET_MODE && ATN) begin
                        atn_seen_q <= 1'b1;
                    end
                    if (TRANSFER_BYTE_COUNTER == `BMD_RST_CNT ||
                        (TARGET_MODE && atn_seen_q && !ATN_FINISH)) begin
                        state_q <= S_END;
                    end
                end
                S_END: begin
                    // Drain: odd byte kept only by a chained move
                    if (!pend_q && !CHAINED_BLOCK_MOVE)
                        have_lo_q <= 1'b0;
                    if (!pend_q && !(have_lo_q && !CHAINED_BLOCK_MOVE)) begin
                        PHASE_OE <= 1'b0;
                        if (CMD_ZERO_INT || atn_seen_q) begin
                            ATN_INT <= atn_seen_q;
                            BUSY <= 1'b0;
                            state_q <= S_HALT;
                        end else begin
                            // Sequential next instruction
                            INSTR_PTR <= INSTR_PTR + `BMD_STEP_TWO;
                            FETCH_ADDR <= INSTR_PTR + `BMD_STEP_TWO;
                            FETCH_REQ <= 1'b1;
                            state_q <= S_F1;
                        end
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end
endmodule // bmd_decoder

//--- hw/bmd_consts.vh
// Constants for the block move instruction decoder
`ifndef BMD_CONSTS_VH
`define BMD_CONSTS_VH

// Instruction type field, bits 31-30 of the first word
`define BMD_TYPE_HI 31
`define BMD_TYPE_LO 30
`define BMD_TYPE_BLOCK 2'h0
`define BMD_TYPE_IORW 2'h1
`define BMD_TYPE_XFER 2'h2
`define BMD_TYPE_MEMMOVE 2'h3

// Field positions of the first word
`define BMD_IO_OP_HI 29
`define BMD_IO_OP_LO 27
`define BMD_IND_BIT 29
`define BMD_TBL_BIT 28
`define BMD_OPC_BIT 27
`define BMD_PH_HI 26
`define BMD_PH_LO 24
`define BMD_CMD_HI 31
`define BMD_CMD_LO 24
`define BMD_CNT_HI 23
`define BMD_CNT_LO 0
`define BMD_OFS_SIGN 23

// Bus phase code of the command phase (MSG, C/D, I/O)
`define BMD_PHASE_CMD 3'h2

// Instruction pointer steps
`define BMD_STEP_TWO 32'h00000008
`define BMD_STEP_THREE 32'h0000000C
`define BMD_WORD_STEP 32'h00000004

// Command length per group code; zero length stops the move
`define BMD_GRP0_LEN 24'h000006
`define BMD_GRP1_LEN 24'h00000A
`define BMD_GRP2_LEN 24'h00000A
`define BMD_GRP3_LEN 24'h000000
`define BMD_GRP4_LEN 24'h000010
`define BMD_GRP5_LEN 24'h00000C

// Reset values
`define BMD_RST_WORD 32'h00000000
`define BMD_RST_CNT 24'h000000

`endif

//--- hw/bmd_grp_len.v
// Command group code to command length decoder
`timescale 1ns/10ps
`include "bmd_consts.vh"
module bmd_grp_len (
    // First command byte
    input wire [7:0] cmd_byte,
    // Decoded length and its validity
    output reg [23:0] cmd_len,
    output reg len_ok
);
    // Group code sits in the top three bits of the byte
    always @* begin
        cmd_len = `BMD_RST_CNT;
        len_ok = 1'b1;
        case (cmd_byte[7:5])
            3'h0: cmd_len = `BMD_GRP0_LEN;
            3'h1: cmd_len = `BMD_GRP1_LEN;
            3'h2: cmd_len = `BMD_GRP2_LEN;
            3'h3: cmd_len = `BMD_GRP3_LEN;
            3'h4: cmd_len = `BMD_GRP4_LEN;
            3'h5: cmd_len = `BMD_GRP5_LEN;
            default: len_ok = 1'b0;
        endcase
    end
endmodule // bmd_grp_len

//--- hw/bmd_buf2.v
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
module bmd_buf2 #(
    parameter W = 49
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Filling side
    input wire in_valid,
    input wire [W-1:0] in_data,
    output wire in_ready,
    // Draining side
    output reg out_valid,
    output reg [W-1:0] out_data,
    input wire out_ready
);
    reg [W-1:0] tail_q;
    reg [1:0] cnt_q;
    wire push;
    wire pop;

    // Head entry is presented directly; tail only holds overflow
    assign in_ready = (cnt_q != 2'h2);
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // Occupancy and entry moves
    always @(posedge clk) begin
        if (rst) begin
            cnt_q <= 2'h0;
            out_valid <= 1'b0;
            out_data <= {W{1'b0}};
            tail_q <= {W{1'b0}};
        end else begin
            case (cnt_q)
                2'h0: begin
                    if (push) begin
                        out_data <= in_data;
                        out_valid <= 1'b1;
                        cnt_q <= 2'h1;
                    end
                end
                2'h1: begin
                    if (push && pop) begin
                        out_data <= in_data;
                    end else if (push) begin
                        tail_q <= in_data;
                        cnt_q <= 2'h2;
                    end else if (pop) begin
                        out_valid <= 1'b0;
                        cnt_q <= 2'h0;
                    end
                end
                2'h2: begin
                    if (pop) begin
                        out_data <= tail_q;
                        cnt_q <= 2'h1;
                    end
                end
                default: cnt_q <= 2'h0;
            endcase
        end
    end
endmodule // bmd_buf2

//--- verif/bmd_mem_model.sv
// System memory model answering instruction and table fetches
`timescale 1ns/10ps
module bmd_mem_model (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Fetch request
    input wire req,
    input wire [31:0] addr,
    output logic ack,
    output logic [31:0] data,
    // Answer latency in cycles
    input wire [3:0] lat
);
    logic [31:0] mem [0:255];
    logic [3:0] cnt;
    // Empty memory reads as zero
    initial begin
        for (int i = 0; i < 256; i++)
            mem[i] = 32'h0;
    end
    // Ack pulse after lat cycles; idle data toggles
    always @(posedge clk) begin
        if (rst) begin
            ack <= 1'b0;
            cnt <= 4'h0;
            data <= 32'h0;
        end else if (req && !ack && cnt >= lat) begin
            ack <= 1'b1;
            cnt <= 4'h0;
            data <= mem[addr[9:2]]; // Word aligned entries
        end else begin
            ack <= 1'b0;
            data <= ~data;
            if (req && !ack) begin
                cnt <= cnt + 4'h1;
            end
        end
    end
endmodule // bmd_mem_model

//--- verif/bmd_monitor.sv
// Concurrent checks on the decoder ports
`timescale 1ns/10ps
module bmd_monitor (
    // Clock and reset
    input wire CLK,
    input wire RST,
    // Control and fetch
    input wire GO,
    input wire [31:0] START_PTR,
    input wire TARGET_MODE,
    input wire FETCH_REQ,
    input wire FETCH_ACK,
    input wire [31:0] FETCH_ADDR,
    // Streams
    input wire IN_VALID,
    input wire IN_READY,
    input wire OUT_VALID,
    input wire OUT_READY,
    input wire [15:0] OUT_DATA,
    input wire [31:0] OUT_ADDR,
    // Decoded state and status
    input wire PHASE_OE,
    input wire [1:0] INSTR_TYPE,
    input wire DONE,
    input wire ILLEGAL_INT,
    input wire MISMATCH_INT,
    input wire CMD_ZERO_INT
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    // Fetch protocol and start
    start_fetch_a: assert property (GO |=> FETCH_REQ && FETCH_ADDR == $past(START_PTR)) else $error("start fetch wrong");
    req_hold_a: assert property (FETCH_REQ && !FETCH_ACK |=> FETCH_REQ && $stable(FETCH_ADDR)) else $error("fetch dropped");
    done_type_a: assert property (DONE |-> INSTR_TYPE != 2'h0) else $error("done on block move");
    // Data stream handshakes
    in_gap_a: assert property (IN_VALID && IN_READY |=> !IN_READY) else $error("byte ready too soon");
    out_hold_a: assert property (OUT_VALID && !OUT_READY |=> OUT_VALID && $stable({OUT_DATA, OUT_ADDR})) else $error("stalled word lost");
    // Phase driving and halts
    oe_target_a: assert property (PHASE_OE |-> TARGET_MODE) else $error("initiator drove phase");
    illegal_halt_a: assert property (ILLEGAL_INT |-> !FETCH_REQ && !PHASE_OE && !IN_READY) else $error("illegal move ran");
    mism_halt_a: assert property (MISMATCH_INT |-> !FETCH_REQ && !IN_READY) else $error("mismatch ran");
    zero_halt_a: assert property (CMD_ZERO_INT |-> !IN_READY && !FETCH_REQ) else $error("zero length ran");
    go_clear_a: assert property (GO |=> !(ILLEGAL_INT || MISMATCH_INT || CMD_ZERO_INT)) else $error("flags not cleared");
    // Main scenarios
    stall_c: cover property (OUT_VALID && !OUT_READY);
    illegal_c: cover property (ILLEGAL_INT);
    zero_c: cover property (CMD_ZERO_INT);
    done_c: cover property (DONE);
endmodule // bmd_monitor

bind bmd_decoder bmd_monitor bmd_monitor_inst (.CLK(CLK), .RST(RST), .GO(GO),
    .START_PTR(START_PTR), .TARGET_MODE(TARGET_MODE), .FETCH_REQ(FETCH_REQ),
    .FETCH_ACK(FETCH_ACK), .FETCH_ADDR(FETCH_ADDR), .IN_VALID(IN_VALID),
    .IN_READY(IN_READY), .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY),
    .OUT_DATA(OUT_DATA), .OUT_ADDR(OUT_ADDR), .PHASE_OE(PHASE_OE),
    .INSTR_TYPE(INSTR_TYPE), .DONE(DONE), .ILLEGAL_INT(ILLEGAL_INT),
    .MISMATCH_INT(MISMATCH_INT), .CMD_ZERO_INT(CMD_ZERO_INT));

//--- verif/testbench.sv
// Testbench running small programs through the decoder
`timescale 1ns/10ps
module testbench;
    logic CLK = 1'b0, RST = 1'b1, GO = 1'b0, IN_VALID = 1'b0;
    logic TARGET_MODE = 1'b0, BUS_READY = 1'b0, PHASE_VALID = 1'b1;
    logic OUT_READY = 1'b0;
    logic [31:0] START_PTR = 32'h0;
    logic [7:0] IN_DATA = 8'h00;
    logic [2:0] LATCHED_PHASE_STATUS = 3'h0;
    logic [3:0] lat = 4'h0;
    wire FETCH_REQ, FETCH_ACK, IN_READY, OUT_VALID, DONE;
    wire ILLEGAL_INT, MISMATCH_INT, CMD_ZERO_INT;
    wire [31:0] FETCH_ADDR, FETCH_DATA, OUT_ADDR, RETURN_STACK_REG, INSTR_PTR;
    wire [15:0] OUT_DATA;
    wire [1:0] INSTR_TYPE;
    wire [2:0] IO_OPCODE;
    int n_fail = 0, total_checks = 0;
    logic [47:0] q[$];
    // Program image as address and word pairs
    localparam logic [63:0] IMG [0:18] = '{64'h0_08000006,
        64'h4_00000100, 64'h8_80000000, 64'h20_C0000000, 64'h28_12345678,
        64'h40_68000000, 64'h50_38000004, 64'h54_00000100, 64'h60_09000004,
        64'h64_00000100, 64'h70_18000002, 64'h74_00FFFFF8, 64'h78_80000000,
        64'h88_00000002, 64'h8C_00000200, 64'hA0_02000010, 64'hB0_08000003,
        64'hB4_00000400, 64'hB8_02000001};
    bmd_decoder bmd_decoder_inst (.CLK(CLK), .RST(RST), .GO(GO),
        .START_PTR(START_PTR), .TARGET_MODE(TARGET_MODE),
        .BUS_READY(BUS_READY), .ATN_FINISH(1'b0), .ATN(1'b0),
        .STRUCTURE_BASE_REG(32'h90), .FETCH_REQ(FETCH_REQ),
        .FETCH_ADDR(FETCH_ADDR), .FETCH_ACK(FETCH_ACK),
        .FETCH_DATA(FETCH_DATA), .PHASE_VALID(PHASE_VALID),
        .LATCHED_PHASE_STATUS(LATCHED_PHASE_STATUS), .PHASE_OUT(),
        .PHASE_OE(), .IN_VALID(IN_VALID), .IN_DATA(IN_DATA),
        .IN_READY(IN_READY), .OUT_VALID(OUT_VALID), .OUT_DATA(OUT_DATA),
        .OUT_ADDR(OUT_ADDR), .OUT_LAST(), .OUT_READY(OUT_READY),
        .INSTR_TYPE(INSTR_TYPE), .IO_OPCODE(IO_OPCODE),
        .COMMAND_CODE_REG(), .TRANSFER_BYTE_COUNTER(),
        .POINTER_SAVE_REG(), .RETURN_STACK_REG(RETURN_STACK_REG),
        .NEXT_DATA_ADDRESS_REG(), .INSTR_PTR(INSTR_PTR),
        .CHAINED_BLOCK_MOVE(), .BUSY(), .DONE(DONE),
        .ILLEGAL_INT(ILLEGAL_INT), .MISMATCH_INT(MISMATCH_INT),
        .CMD_ZERO_INT(CMD_ZERO_INT), .ATN_INT());
    bmd_mem_model bmd_mem_model_inst (.clk(CLK), .rst(RST), .req(FETCH_REQ),
        .addr(FETCH_ADDR), .ack(FETCH_ACK), .data(FETCH_DATA), .lat(lat));
    // Clock and collection of accepted words
    always #10 CLK = ~CLK;
    always @(posedge CLK) begin
        if (OUT_VALID === 1'b1 && OUT_READY) begin
            q.push_back({OUT_ADDR, OUT_DATA});
        end
    end
    task automatic chk(logic [47:0] s, logic [47:0] e);
        total_checks++;
        if (s !== e) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic ckq(logic [47:0] e);
        chk(q.size() > 0 ? q.pop_front() : 48'hx, e);
    endtask
    task automatic test_done();
        $display("checks=%0d mismatches=%0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic tmo(int k);
        if (k == 400) begin
            n_fail++;
            test_done();
        end
    endtask
    // Run a program to its end or a halt
    task automatic run(logic [31:0] p);
        int i;
        @(posedge CLK);
        GO <= 1'b1;
        START_PTR <= p;
        @(posedge CLK);
        GO <= 1'b0;
        for (i = 0; i < 400; i++) begin
            @(posedge CLK);
            if ((DONE | ILLEGAL_INT | MISMATCH_INT | CMD_ZERO_INT) === 1'b1)
                break;
        end
        tmo(i);
        repeat (3) @(posedge CLK);
        $display("test at %h ended", p);
    endtask
    // Offer n bytes counting up from b
    task automatic send(int n, logic [7:0] b);
        int i, k;
        for (i = 0; i < n; i++) begin
            IN_VALID <= 1'b1;
            IN_DATA <= b + 8'(i);
            for (k = 0; k < 400 && IN_READY !== 1'b1; k++) @(posedge CLK);
            tmo(k);
            @(posedge CLK);
        end
        IN_VALID <= 1'b0;
    endtask
    // Main sequence
    initial begin
        repeat (2) @(posedge CLK);
        for (int i = 0; i < 19; i++) begin
            bmd_mem_model_inst.mem[IMG[i][41:34]] = IMG[i][31:0];
        end
        RST <= 1'b0;
        fork
            run(32'h0);
            send(6, 8'hA0);
            begin
                repeat (40) @(posedge CLK);
                OUT_READY <= 1'b1;
            end
        join
        ckq({32'h100, 16'hA1A0});
        ckq({32'h102, 16'hA3A2});
        ckq({32'h104, 16'hA5A4});
        chk(INSTR_PTR, 32'h10);
        chk(INSTR_TYPE, 2'h2);
        lat <= 4'h3;
        run(32'h20);
        chk(RETURN_STACK_REG, 32'h12345678);
        chk(INSTR_PTR, 32'h2C);
        chk(INSTR_TYPE, 2'h3);
        run(32'h40);
        chk(IO_OPCODE, 3'h5);
        chk(INSTR_TYPE, 2'h1);
        run(32'h50);
        chk(ILLEGAL_INT, 1'b1);
        chk(q.size(), 0);
        run(32'h60);
        chk(MISMATCH_INT, 1'b1);
        fork
            run(32'h70);
            send(2, 8'hB0);
        join
        ckq({32'h200, 16'hB1B0});
        chk(INSTR_PTR, 32'h80);
        TARGET_MODE <= 1'b1;
        BUS_READY <= 1'b1;
        fork
            run(32'hA0);
            send(1, 8'h60);
        join
        chk(CMD_ZERO_INT, 1'b1);
        ckq(48'h60);
        fork
            run(32'hB0);
            send(4, 8'h5E);
        join
        ckq({32'h400, 16'h5F5E});
        ckq({32'h402, 16'h6160});
        test_done();
    end
endmodule // testbench
